// ===== common/eic_pkg.sv
// Constants and types of the external pin interrupt configuration block
package eic_pkg;

  // ----------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------
  localparam int EIC_CHANNELS   = 8;
  localparam int EIC_ADDR_W     = 12;
  localparam int EIC_DATA_W     = 32;
  localparam int EIC_CFG_W      = 16;
  localparam int EIC_CH_PER_REG = 4;

  // ----------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------
  localparam logic [11:0] EIC_ADDR_CFG_LO = 12'ha20;
  localparam logic [11:0] EIC_ADDR_CFG_HI = 12'ha24;
  localparam logic [11:0] EIC_ADDR_STATUS = 12'ha40;
  localparam logic [11:0] EIC_ADDR_MASK   = 12'ha44;

  // ----------------------------------------------------------
  // Channel field layout inside a config register
  // ----------------------------------------------------------
  localparam int EIC_FIELD_W = 4;
  localparam int EIC_EN_POS  = 3;
  localparam int EIC_MODE_W  = 3;

  // ----------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------
  localparam logic [15:0] EIC_CFG_RST    = 16'h0000;
  localparam logic [7:0]  EIC_STATUS_RST = 8'h00;
  localparam logic [7:0]  EIC_MASK_RST   = 8'h00;

  // ----------------------------------------------------------
  // Trigger mode codes
  // ----------------------------------------------------------
  localparam logic [2:0] EIC_MODE_RISE     = 3'h0;
  localparam logic [2:0] EIC_MODE_FALL     = 3'h1;
  localparam logic [2:0] EIC_MODE_BOTH     = 3'h2;
  localparam logic [2:0] EIC_MODE_HIGH     = 3'h3;
  localparam logic [2:0] EIC_MODE_LOW      = 3'h4;
  localparam logic [2:0] EIC_MODE_FALL_ALT = 3'h5;
  localparam logic [2:0] EIC_MODE_BOTH_ALT = 3'h6;
  localparam logic [2:0] EIC_MODE_HIGH_ALT = 3'h7;

  // ----------------------------------------------------------
  // State types
  // ----------------------------------------------------------
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } eic_det_state_t;

  localparam eic_det_state_t EIC_DET_RST = '0;

  typedef struct packed {
    logic [15:0] cfg_lo;
    logic [15:0] cfg_hi;
    logic [7:0]  status;
    logic [7:0]  mask;
    logic [7:0]  armed;
    logic        hib_prev;
    logic [31:0] prdata;
  } eic_state_t;

  localparam eic_state_t EIC_STATE_RST = '0;

endpackage : eic_pkg

// ===== common/eic_chan_if.sv
// Per-channel link between the register file and one pin detector
`timescale 1ns/1ps
`default_nettype none

interface eic_chan_if;
  logic                           enable;
  logic [eic_pkg::EIC_MODE_W-1:0] mode;
  logic                           hit;

  modport cfg (output enable, output mode, input hit);
  modport det (input enable, input mode, output hit);
endinterface : eic_chan_if

`default_nettype wire

// ===== core/eic_chan_detect.sv
// Pin synchroniser and trigger detector for one external channel
`timescale 1ns/1ps
`default_nettype none

module eic_chan_detect
  import eic_pkg::*;
(
  input  wire logic i_clock,
  input  wire logic i_reset,
  input  wire logic i_pin,
  eic_chan_if.det   det
);

  eic_det_state_t st_reg;
  eic_det_state_t st_next;
  logic           rise;
  logic           fall;
  logic           trig;

  // Two-flop synchroniser, then one sample of history
  always_comb begin
    st_next      = st_reg;
    st_next.meta = i_pin;
    st_next.sync = st_reg.meta;
    st_next.prev = st_reg.sync;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      st_reg <= EIC_DET_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Edges seen only past the second flop
  assign rise = st_reg.sync & ~st_reg.prev;
  assign fall = ~st_reg.sync & st_reg.prev;

  // Trigger decode, alias codes folded onto base modes
  always_comb begin
    case (det.mode)
      EIC_MODE_RISE:     trig = rise;
      EIC_MODE_FALL:     trig = fall;
      EIC_MODE_BOTH:     trig = rise | fall;
      EIC_MODE_HIGH:     trig = st_reg.sync;
      EIC_MODE_LOW:      trig = ~st_reg.sync;
      EIC_MODE_FALL_ALT: trig = fall;
      EIC_MODE_BOTH_ALT: trig = rise | fall;
      EIC_MODE_HIGH_ALT: trig = st_reg.sync;
      default:           trig = 1'b0;
    endcase
  end

  // Disabled channel stays silent
  assign det.hit = det.enable & trig;

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  sequence s_pin_rise;
    !i_pin ##1 i_pin;
  endsequence

  sequence s_pin_fall;
    i_pin ##1 !i_pin;
  endsequence

  a_off_silent: assert property (
    !det.enable |-> !det.hit
  ) else $error("disabled channel raised an event");

  a_rise_seen: assert property (
    s_pin_rise ##2 (det.enable && det.mode == EIC_MODE_RISE)
      |-> det.hit
  ) else $error("rising edge not seen two cycles on");

  a_rise_only: assert property (
    s_pin_fall ##2 (det.enable && det.mode == EIC_MODE_RISE)
      |-> !det.hit
  ) else $error("rising mode fired on a falling edge");

  a_fall_alias: assert property (
    s_pin_fall ##2 (det.enable && det.mode == EIC_MODE_FALL_ALT)
      |-> det.hit
  ) else $error("alias falling mode missed an edge");

  a_high_hold: assert property (
    i_pin [*3] ##2 (det.enable && det.mode == EIC_MODE_HIGH_ALT)
      |-> det.hit
  ) else $error("high level not held as event");

  a_low_hold: assert property (
    !i_pin [*3] ##2 (det.enable && det.mode == EIC_MODE_LOW)
      |-> det.hit
  ) else $error("low level not held as event");

endmodule : eic_chan_detect

`default_nettype wire

// ===== core/eic_top.sv
// External pin interrupt configuration block with APB register file
//
// Contract
// - Channel 0 enable bit 3, mode 2:0
// - Enable low ignores pin; high detects mode
// - Enabled before hibernate, event wakes device
// - Modes: rise, fall, both, high, low
// - Codes 101,110,111 alias fall, both, high
// - Channel 1 enable bit 7, mode 6:4
// - Channel 7 upper enable 15, mode 14:12
// - Channel 6 upper enable 11, mode below
// - All fields reset zero, registers read-write
// - Channels 2,3 enables 11,15, modes below
// - Lower config 0xa20, upper next word
`timescale 1ns/1ps
`default_nettype none

module eic_top
  import eic_pkg::*;
(
  input  wire logic                    i_clock,
  input  wire logic                    i_reset,
  input  wire logic                    i_psel,
  input  wire logic                    i_penable,
  input  wire logic                    i_pwrite,
  input  wire logic [EIC_ADDR_W-1:0]   i_paddr,
  input  wire logic [EIC_DATA_W-1:0]   i_pwdata,
  input  wire logic [3:0]              i_pstrb,
  output logic      [EIC_DATA_W-1:0]   o_prdata,
  output logic                         o_pready,
  output logic                         o_pslverr,
  input  wire logic [EIC_CHANNELS-1:0] i_pins,
  input  wire logic                    i_hibernate,
  output logic                         o_irq,
  output logic                         o_wake
);

  // ----------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------
  eic_state_t              st_reg;
  eic_state_t              st_next;
  logic                    setup;
  logic                    acc;
  logic                    wr_acc;
  logic                    addr_ok;
  logic [EIC_DATA_W-1:0]   rd_mux;
  logic [EIC_CHANNELS-1:0] evt_vec;
  logic [EIC_CHANNELS-1:0] chan_en;
  logic [EIC_CHANNELS-1:0] rd_clr;

  eic_chan_if chif [EIC_CHANNELS] ();

  // ----------------------------------------------------------
  // Byte lane merge for the 16-bit config registers
  // ----------------------------------------------------------
  function automatic logic [15:0] lane_merge(
    input logic [15:0] old_val,
    input logic [31:0] wdata,
    input logic [3:0]  strb
  );
    logic [15:0] res;
    res = old_val;
    if (strb[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (strb[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction : lane_merge

  // ----------------------------------------------------------
  // APB phase decode
  // ----------------------------------------------------------
  // Zero wait states: read data is caught in the setup cycle
  assign setup  = i_psel & ~i_penable;
  assign acc    = i_psel & i_penable;
  assign wr_acc = acc & i_pwrite;

  // Exact match, so unaligned addresses count as unmapped
  always_comb begin
    case (i_paddr)
      EIC_ADDR_CFG_LO: addr_ok = 1'b1;
      EIC_ADDR_CFG_HI: addr_ok = 1'b1;
      EIC_ADDR_STATUS: addr_ok = 1'b1;
      EIC_ADDR_MASK:   addr_ok = 1'b1;
      default:         addr_ok = 1'b0;
    endcase
  end

  // Handshake outputs
  assign o_pready  = acc;
  assign o_pslverr = acc & ~addr_ok;

  // ----------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------
  // Narrow registers sit in the low bits, upper bits read zero
  always_comb begin
    case (i_paddr)
      EIC_ADDR_CFG_LO: rd_mux = {16'h0000, st_reg.cfg_lo};
      EIC_ADDR_CFG_HI: rd_mux = {16'h0000, st_reg.cfg_hi};
      EIC_ADDR_STATUS: rd_mux = {24'h000000, st_reg.status};
      EIC_ADDR_MASK:   rd_mux = {24'h000000, st_reg.mask};
      default:         rd_mux = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------
  // Read-to-clear of the event status
  // ----------------------------------------------------------
  // Only the bits software actually saw are cleared; an event
  // landing between setup and access survives to the next read
  always_comb begin
    if (acc && !i_pwrite && i_paddr == EIC_ADDR_STATUS) begin
      rd_clr = st_reg.prdata[EIC_CHANNELS-1:0];
    end else begin
      rd_clr = '0;
    end
  end

  // ----------------------------------------------------------
  // Channel detectors
  // ----------------------------------------------------------
  // Four channels per register, four bits per channel
  for (genvar g = 0; g < EIC_CHANNELS; g++) begin : g_chan
    localparam int K = (g % EIC_CH_PER_REG) * EIC_FIELD_W;
    logic [EIC_CFG_W-1:0] cfg;

    // Lower register holds 0..3, upper holds 4..7
    assign cfg = (g < EIC_CH_PER_REG) ? st_reg.cfg_lo
                                      : st_reg.cfg_hi;
    // Enable on the top bit, mode in the three below
    assign chif[g].enable = cfg[K + EIC_EN_POS];
    assign chif[g].mode   = cfg[K +: EIC_MODE_W];
    assign evt_vec[g]     = chif[g].hit;
    assign chan_en[g]     = chif[g].enable;

    eic_chan_detect u_det (
      .i_clock (i_clock),
      .i_reset (i_reset),
      .i_pin   (i_pins[g]),
      .det     (chif[g])
    );
  end

  // ----------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------
  always_comb begin
    st_next          = st_reg;
    st_next.hib_prev = i_hibernate;

    // Enables are frozen as wake sources on hibernate entry
    if (i_hibernate && !st_reg.hib_prev) begin
      st_next.armed = chan_en;
    end

    // Snapshot of read data during the setup cycle
    if (setup && !i_pwrite) begin
      st_next.prdata = rd_mux;
    end

    // Register writes take effect at the access edge
    if (wr_acc) begin
      case (i_paddr)
        EIC_ADDR_CFG_LO: begin
          st_next.cfg_lo = lane_merge(st_reg.cfg_lo, i_pwdata,
                                      i_pstrb);
        end
        EIC_ADDR_CFG_HI: begin
          st_next.cfg_hi = lane_merge(st_reg.cfg_hi, i_pwdata,
                                      i_pstrb);
        end
        EIC_ADDR_MASK: begin
          if (i_pstrb[0]) begin
            st_next.mask = i_pwdata[7:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Sticky events; a new event wins over the read clear
    st_next.status = (st_reg.status & ~rd_clr) | evt_vec;
  end

  // ----------------------------------------------------------
  // State register
  // ----------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      st_reg <= EIC_STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------
  assign o_prdata = st_reg.prdata;
  assign o_irq    = |(st_reg.status & st_reg.mask);

  // Wake needs a full cycle in hibernate so arming has settled
  assign o_wake = i_hibernate & st_reg.hib_prev
                & |(evt_vec & st_reg.armed);

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  sequence s_wr_full(logic [11:0] addr);
    i_psel && i_penable && i_pwrite && i_paddr == addr
      && i_pstrb == 4'hf;
  endsequence

  sequence s_rd_setup(logic [11:0] addr);
    i_psel && !i_penable && !i_pwrite && i_paddr == addr;
  endsequence

  sequence s_hib_enter(logic armed_bit);
    !i_hibernate ##1 (i_hibernate && chan_en[0] == armed_bit);
  endsequence

  a_ch0_field: assert property (
    s_wr_full(EIC_ADDR_CFG_LO) |=>
      chif[0].enable == $past(i_pwdata[3])
      && chif[0].mode == $past(i_pwdata[2:0])
  ) else $error("channel 0 field not taken from write");

  a_ch1_field: assert property (
    s_wr_full(EIC_ADDR_CFG_LO) |=>
      chif[1].enable == $past(i_pwdata[7])
      && chif[1].mode == $past(i_pwdata[6:4])
  ) else $error("channel 1 field not taken from write");

  a_ch23_field: assert property (
    s_wr_full(EIC_ADDR_CFG_LO) |=>
      chif[2].enable == $past(i_pwdata[11])
      && chif[2].mode == $past(i_pwdata[10:8])
      && chif[3].enable == $past(i_pwdata[15])
      && chif[3].mode == $past(i_pwdata[14:12])
  ) else $error("channel 2 or 3 field wrong");

  a_ch7_field: assert property (
    s_wr_full(EIC_ADDR_CFG_HI) |=>
      chif[7].enable == $past(i_pwdata[15])
      && chif[7].mode == $past(i_pwdata[14:12])
  ) else $error("channel 7 field not taken from write");

  a_ch6_field: assert property (
    s_wr_full(EIC_ADDR_CFG_HI) |=>
      chif[6].enable == $past(i_pwdata[11])
      && chif[6].mode == $past(i_pwdata[10:8])
  ) else $error("channel 6 field not taken from write");

  a_reset_zero: assert property (
    @(posedge i_clock) disable iff (1'b0)
    i_reset |=> st_reg.cfg_lo == EIC_CFG_RST
      && st_reg.cfg_hi == EIC_CFG_RST
      && st_reg.mask == EIC_MASK_RST && !o_irq && !o_wake
  ) else $error("config not zero after reset");

  a_map_lo: assert property (
    s_rd_setup(EIC_ADDR_CFG_LO) |=>
      o_pready && !o_pslverr
      && o_prdata == {16'h0000, $past(st_reg.cfg_lo)}
  ) else $error("lower config not at its address");

  a_map_hi: assert property (
    s_rd_setup(EIC_ADDR_CFG_HI) |=>
      o_pready && !o_pslverr
      && o_prdata == {16'h0000, $past(st_reg.cfg_hi)}
  ) else $error("upper config not at next word");

  a_wake_armed: assert property (
    s_hib_enter(1'b1) ##1 (i_hibernate && evt_vec[0])
      |-> o_wake
  ) else $error("armed pin event did not wake");

  a_wake_unarmed: assert property (
    s_hib_enter(1'b0) ##1 (i_hibernate && evt_vec == 8'h01)
      |-> !o_wake
  ) else $error("pin not armed before hibernate woke");

  a_status_set: assert property (
    (evt_vec != 8'h00) |=>
      (st_reg.status & $past(evt_vec)) == $past(evt_vec)
  ) else $error("event lost in status");

  a_irq_level: assert property (
    (st_reg.status[0] && st_reg.mask[0]) |-> o_irq
  ) else $error("unmasked status did not raise irq");

  // Wake sources are snapshotted on entry and frozen while asleep
  a_arm_capture: assert property (
    $rose(i_hibernate) |=> st_reg.armed == $past(chan_en)
  ) else $error("wake sources not captured on entry");

  a_arm_hold: assert property (
    (i_hibernate && st_reg.hib_prev) |=> $stable(st_reg.armed)
  ) else $error("wake sources changed during hibernate");

  a_wake_awake: assert property (
    !i_hibernate |-> !o_wake
  ) else $error("wake raised outside hibernate");

  a_wake_stray: assert property (
    (evt_vec & st_reg.armed) == 8'h00 |-> !o_wake
  ) else $error("event on a pin not armed woke the device");

  // Only bits handed to software are cleared, and only on access
  a_read_clear: assert property (
    s_rd_setup(EIC_ADDR_STATUS)
      ##1 (i_psel && i_penable && evt_vec == 8'h00)
      |=> (st_reg.status & $past(st_reg.prdata[7:0])) == 8'h00
  ) else $error("status bits read were not cleared");

  a_unmapped_read: assert property (
    (i_psel && !i_penable && !i_pwrite && !addr_ok)
      |=> o_prdata == 32'h00000000
  ) else $error("unmapped read returned data");

  a_err_unmapped: assert property (
    (i_psel && i_penable && !addr_ok) |-> o_pready && o_pslverr
  ) else $error("unmapped access not flagged");

  // Lane strobes gate each byte of the config words, so software
  // can change two channels without touching the other two
  a_strb_keep: assert property (
    (i_psel && i_penable && i_pwrite && i_paddr == EIC_ADDR_CFG_LO
      && !i_pstrb[0]) |=> $stable(st_reg.cfg_lo[7:0])
  ) else $error("unstrobed low lane of config written");

  a_strb_take: assert property (
    (i_psel && i_penable && i_pwrite && i_paddr == EIC_ADDR_CFG_LO
      && i_pstrb[1]) |=> st_reg.cfg_lo[15:8] == $past(i_pwdata[15:8])
  ) else $error("strobed high lane of config not written");

  a_status_ro: assert property (
    (i_psel && i_penable && i_pwrite && i_paddr == EIC_ADDR_STATUS)
      |=> st_reg.status == ($past(st_reg.status) | $past(evt_vec))
  ) else $error("write changed the event status");

  a_irq_quiet: assert property (
    (st_reg.status & st_reg.mask) == 8'h00 |-> !o_irq
  ) else $error("irq raised with no unmasked status");

endmodule : eic_top

`default_nettype wire

// ===== test/eic_pin_model.sv
// Behavioural model of the external signals on the interrupt pins
`timescale 1ns/1ps
`default_nettype none

module eic_pin_model
  import eic_pkg::*;
(
  input  wire logic                    i_clock,
  output logic      [EIC_CHANNELS-1:0] o_pins
);
  // ----------------------------------------------------------
  // Pin levels
  // ----------------------------------------------------------
  // Pins idle low; a new level lands just after a rising edge and is held
  // for whole cycles, since shorter pulses may slip past the synchroniser
  initial o_pins = '0;

  task automatic drive(input logic [EIC_CHANNELS-1:0] level);
    @(posedge i_clock);
    o_pins <= level;
  endtask : drive
endmodule : eic_pin_model

`default_nettype wire

// ===== test/eic_top_test.sv
// Self-checking bench for the external pin interrupt configuration block
`timescale 1ns/1ps
`default_nettype none

module eic_top_test;
  import eic_pkg::*;

  // ----------------------------------------------------------
  // Signals
  // ----------------------------------------------------------
  logic                    i_clock;
  logic                    i_reset;
  logic                    i_psel;
  logic                    i_penable;
  logic                    i_pwrite;
  logic [EIC_ADDR_W-1:0]   i_paddr;
  logic [EIC_DATA_W-1:0]   i_pwdata;
  logic [3:0]              i_pstrb;
  logic [EIC_DATA_W-1:0]   o_prdata;
  logic                    o_pready;
  logic                    o_pslverr;
  logic [EIC_CHANNELS-1:0] pins;
  logic                    i_hibernate;
  logic                    o_irq;
  logic                    o_wake;
  int                      failures;
  int                      total_checks;
  int                      cycles;
  logic [31:0]             rd;
  logic                    err;
  logic [15:0]             field;
  logic                    seen;

  eic_top eic_top_i (
    .i_clock(i_clock), .i_reset(i_reset), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_pins(pins),
    .i_hibernate(i_hibernate), .o_irq(o_irq), .o_wake(o_wake)
  );

  eic_pin_model eic_pin_model_i (.i_clock(i_clock), .o_pins(pins));

  // ----------------------------------------------------------
  // Clock, timeout and reporting
  // ----------------------------------------------------------
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end

  // Whole run needs under a thousand cycles; the ceiling leaves ample slack
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen_v, input logic [31:0] exp);
    total_checks++;
    if (seen_v !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen_v, exp);
    end
  endtask : check

  // ----------------------------------------------------------
  // APB master tasks
  // ----------------------------------------------------------
  // Request is held until pready is sampled high; no latency is assumed
  task automatic apb_xfer(input logic wr, input logic [EIC_ADDR_W-1:0] a,
                          input logic [31:0] wd, output logic [31:0] rdata,
                          output logic e);
    @(posedge i_clock);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= wr;
    i_paddr   <= a;
    i_pwdata  <= wd;
    @(posedge i_clock);
    i_penable <= 1'b1;
    // A stalled slave is ended only by the bench timeout
    do begin
      @(posedge i_clock);
    end while (o_pready !== 1'b1);
    rdata = o_prdata;
    e     = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb_xfer

  task automatic apb_write(input logic [EIC_ADDR_W-1:0] a,
                           input logic [31:0] wd);
    logic [31:0] d;
    logic        e;
    apb_xfer(1'b1, a, wd, d, e);
  endtask : apb_write

  task automatic rd_check(input logic [EIC_ADDR_W-1:0] a,
                          input logic [31:0] exp);
    logic [31:0] d;
    logic        e;
    apb_xfer(1'b0, a, 32'h0000_0000, d, e);
    check(d, exp);
  endtask : rd_check

  // Drive pins, then let synchroniser and detector settle
  task automatic set_pins(input logic [EIC_CHANNELS-1:0] v);
    eic_pin_model_i.drive(v);
    repeat (8) @(posedge i_clock);
  endtask : set_pins

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    i_reset = 1'b1;  i_psel = 1'b0;  i_penable = 1'b0;  i_pwrite = 1'b0;
    i_paddr = '0;  i_pwdata = '0;  i_pstrb = 4'hf;  i_hibernate = 1'b0;
    failures = 0;  total_checks = 0;  cycles = 0;
    repeat (2) @(posedge i_clock);
    i_reset <= 1'b0;
    // Reset values, read-back and decode
    rd_check(EIC_ADDR_CFG_LO, 32'h0000_0000);
    rd_check(EIC_ADDR_CFG_HI, 32'h0000_0000);
    rd_check(EIC_ADDR_MASK, 32'h0000_0000);
    rd_check(EIC_ADDR_STATUS, 32'h0000_0000);
    apb_write(EIC_ADDR_CFG_LO, 32'hffff_ffff);
    apb_write(EIC_ADDR_CFG_HI, 32'h0000_a5c3);
    rd_check(EIC_ADDR_CFG_LO, 32'h0000_ffff);
    rd_check(EIC_ADDR_CFG_HI, 32'h0000_a5c3);
    // Status ignores writes; channel 5 in low mode keeps its bit set
    apb_write(EIC_ADDR_STATUS, 32'h0000_00ff);
    rd_check(EIC_ADDR_STATUS, 32'h0000_0020);
    // Only the strobed byte lane of a config word is written
    i_pstrb <= 4'h2;
    apb_write(EIC_ADDR_CFG_LO, 32'h0000_1234);
    i_pstrb <= 4'hf;
    rd_check(EIC_ADDR_CFG_LO, 32'h0000_12ff);
    apb_xfer(1'b0, 12'hffc, 32'h0000_0000, rd, err);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    $display("test registers done");
    // Every mode code on all channels: edge hits and level persistence
    for (int m = 0; m < 8; m++) begin
      field = {4{1'b1, m[2:0]}};
      apb_write(EIC_ADDR_CFG_LO, {16'h0000, field});
      apb_write(EIC_ADDR_CFG_HI, {16'h0000, field});
      set_pins(8'h00);
      apb_xfer(1'b0, EIC_ADDR_STATUS, 32'h0, rd, err);
      rd_check(EIC_ADDR_STATUS, (m == 4) ? 32'hff : 32'h0);
      set_pins(8'hff);
      rd_check(EIC_ADDR_STATUS, (m == 1 || m == 5) ? 32'h0 : 32'hff);
      rd_check(EIC_ADDR_STATUS, (m[1:0] == 2'h3) ? 32'hff : 32'h0);
      set_pins(8'h00);
      rd_check(EIC_ADDR_STATUS, (m == 0) ? 32'h0 : 32'hff);
    end
    $display("test modes done");
    // One channel enabled at a time in high-level mode
    for (int ch = 0; ch < 8; ch++) begin
      field = 16'h000b << (4 * (ch % 4));
      apb_write(EIC_ADDR_CFG_LO, (ch < 4) ? {16'h0, field} : 32'h0);
      apb_write(EIC_ADDR_CFG_HI, (ch < 4) ? 32'h0 : {16'h0, field});
      set_pins(8'hff);
      apb_xfer(1'b0, EIC_ADDR_STATUS, 32'h0, rd, err);
      rd_check(EIC_ADDR_STATUS, 32'h1 << ch);
    end
    $display("test layout done");
    // Interrupt raised when unmasked, cleared by status read, masked off
    apb_write(EIC_ADDR_CFG_LO, 32'h0000_0008);
    apb_write(EIC_ADDR_CFG_HI, 32'h0);
    set_pins(8'h00);
    apb_xfer(1'b0, EIC_ADDR_STATUS, 32'h0, rd, err);
    apb_write(EIC_ADDR_MASK, 32'h0000_0001);
    rd_check(EIC_ADDR_MASK, 32'h0000_0001);
    set_pins(8'h01);
    check({31'h0, o_irq}, 32'h1);
    rd_check(EIC_ADDR_STATUS, 32'h1);
    // The clear lands at the access edge; look one edge later
    @(posedge i_clock);
    check({31'h0, o_irq}, 32'h0);
    apb_write(EIC_ADDR_MASK, 32'h0);
    set_pins(8'h00);
    set_pins(8'h01);
    check({31'h0, o_irq}, 32'h0);
    rd_check(EIC_ADDR_STATUS, 32'h1);
    $display("test interrupt done");
    // Wake only from a channel armed before hibernate entry
    apb_write(EIC_ADDR_CFG_LO, 32'h0000_0080);
    set_pins(8'h00);
    i_hibernate <= 1'b1;
    repeat (4) @(posedge i_clock);
    apb_write(EIC_ADDR_CFG_LO, 32'h0000_0088);
    eic_pin_model_i.drive(8'h01);
    seen = 1'b0;
    repeat (8) @(posedge i_clock) if (o_wake === 1'b1) seen = 1'b1;
    check({31'h0, seen}, 32'h0);
    eic_pin_model_i.drive(8'h03);
    seen = 1'b0;
    repeat (8) @(posedge i_clock) if (o_wake === 1'b1) seen = 1'b1;
    check({31'h0, seen}, 32'h1);
    i_hibernate <= 1'b0;
    $display("test hibernate done");
    stop_test();
  end
endmodule : eic_top_test

`default_nettype wire
